/* rtl/cmpref_top.sv */
// Comparator reference control: AXI4-Lite registers, ladder control, comparator events
//
// Behaviour
// - Enabled comparators keep running in sleep; enabled interrupts still wake.
// - Leaving sleep keeps both comparator control registers unchanged.
// - Reset clears both comparator controls, turning comparators and reference off.
// - Reference bit 7 powers the ladder on when one, off when zero.
// - Reference bit 6 routes ladder level to shared pin, overriding direction.
// - Bit 5 one picks low range, zero picks the high range.
// - Bit 4 one picks external reference pins, zero analog supply.
// - Bits 3:0 pick one of sixteen levels within the chosen range.
// - Waking from sleep by any cause keeps the reference control unchanged.
// - Reset clears enable, pin drive, range and tap code bits.
// - Reference works independently, also with both comparators off.
// - Comparator bit 7 switches the comparator on or off.
// - Comparator bit 2 picks external pin or ladder level as positive input.
// - Bits 4:3 pick rising, falling or any change as interrupt event.
// - Bit 5 inverts the output before status, pin and event detection.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "cmpref_cfg.svh"
module cmpref_top
    import cmpref_pkg::*;
#(
    parameter int ADDR_W = `CMPREF_ADDR_W
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Power state
    input wire logic sleep_active,
    output logic wake_req,
    // Ladder controls
    output logic ref_power_on,
    output logic ref_range_select,
    output logic ref_source_select,
    output logic [3:0] ref_tap_code,
    // Shared analog pin
    input wire logic pin_direction,
    output logic ref_pin_drive,
    output logic shared_pin_digital_oe,
    // Comparator analog side
    input wire logic [1:0] comparator_raw,
    output logic [1:0] comparator_on,
    output logic [1:0] positive_input_select,
    output logic [3:0] negative_channel_select,
    // Comparator digital outputs
    output logic [1:0] comparator_pin_drive,
    output logic comparator_one_result,
    output logic comparator_two_result,
    // Interrupt
    output logic irq
);
    localparam logic [ADDR_W-1:0] A_REF = ADDR_W'(`CMPREF_BYTE_ADDR(`CMPREF_IDX_REF_CTRL));
    localparam logic [ADDR_W-1:0] A_CMP1 = ADDR_W'(`CMPREF_BYTE_ADDR(`CMPREF_IDX_CMP1_CTRL));
    localparam logic [ADDR_W-1:0] A_CMP2 = ADDR_W'(`CMPREF_BYTE_ADDR(`CMPREF_IDX_CMP2_CTRL));
    localparam logic [ADDR_W-1:0] A_STAT = ADDR_W'(`CMPREF_BYTE_ADDR(`CMPREF_IDX_CMP_STAT));
    localparam logic [ADDR_W-1:0] A_IST = ADDR_W'(`CMPREF_BYTE_ADDR(`CMPREF_IDX_INT_STAT));
    localparam logic [ADDR_W-1:0] A_IMSK = ADDR_W'(`CMPREF_BYTE_ADDR(`CMPREF_IDX_INT_MASK));

    // Register state
    cmpref_byte_t voltage_reference_control_r;
    cmpref_byte_t comparator_one_control_r;
    cmpref_byte_t comparator_two_control_r;
    logic [1:0] comparator_event_flag_r;
    logic [1:0] int_mask_r;

    // Write channel state
    cmpref_wr_state_t wr_state_r;
    logic aw_held_r;
    logic w_held_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [7:0] w_data_r;
    logic w_lane0_r;
    logic wr_commit;
    logic wr_hit;
    logic [1:0] bresp_r;

    // Read channel state
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [7:0] rd_byte;
    logic rd_hit;

    // Comparator channel results
    logic [1:0] result;
    logic [1:0] event_pulse;
    logic [1:0] chan_on;
    logic [1:0] chan_pin;
    logic [1:0] chan_pos;
    logic [1:0] neg0;
    logic [1:0] neg1;

    // Write path: address and data are taken in either order
    assign awready = ~aw_held_r & (wr_state_r == WR_IDLE);
    assign wready = ~w_held_r & (wr_state_r == WR_IDLE);
    assign wr_commit = aw_held_r & w_held_r & (wr_state_r == WR_IDLE);
    assign bvalid = (wr_state_r == WR_RESP);
    assign bresp = bresp_r;

    always_comb
    begin
        case (aw_addr_r)
            A_REF, A_CMP1, A_CMP2, A_STAT, A_IST, A_IMSK: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
        end
        else if (wr_commit)
        begin
            aw_held_r <= 1'b0;
        end
        else if (awvalid && awready)
        begin
            aw_held_r <= 1'b1;
            aw_addr_r <= awaddr;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held_r <= 1'b0;
            w_data_r <= 8'h00;
            w_lane0_r <= 1'b0;
        end
        else if (wr_commit)
        begin
            w_held_r <= 1'b0;
        end
        else if (wvalid && wready)
        begin
            w_held_r <= 1'b1;
            w_data_r <= wdata[7:0];
            w_lane0_r <= wstrb[0];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_state_r <= WR_IDLE;
            bresp_r <= `CMPREF_RESP_OKAY;
        end
        else
        begin
            case (wr_state_r)
                WR_IDLE:
                begin
                    if (wr_commit)
                    begin
                        wr_state_r <= WR_RESP;
                        bresp_r <= wr_hit ? `CMPREF_RESP_OKAY : `CMPREF_RESP_SLVERR;
                    end
                end
                WR_RESP:
                begin
                    if (bready)
                    begin
                        wr_state_r <= WR_IDLE;
                    end
                end
                default: wr_state_r <= WR_IDLE;
            endcase
        end
    end

    // Control registers; sleep never touches them, only writes and reset do
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            voltage_reference_control_r <= `CMPREF_REF_RESET;
        end
        else if (wr_commit && w_lane0_r && aw_addr_r == A_REF)
        begin
            voltage_reference_control_r <= w_data_r;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            comparator_one_control_r <= `CMPREF_CMP_RESET;
            comparator_two_control_r <= `CMPREF_CMP_RESET;
        end
        else if (wr_commit && w_lane0_r)
        begin
            if (aw_addr_r == A_CMP1)
            begin
                comparator_one_control_r <= w_data_r;
            end
            if (aw_addr_r == A_CMP2)
            begin
                comparator_two_control_r <= w_data_r;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            int_mask_r <= `CMPREF_MASK_RESET;
        end
        else if (wr_commit && w_lane0_r && aw_addr_r == A_IMSK)
        begin
            int_mask_r <= w_data_r[1:0];
        end
    end

    // Sticky event flags; a new event beats a same-cycle clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            comparator_event_flag_r <= 2'h0;
        end
        else if (wr_commit && w_lane0_r && aw_addr_r == A_IST)
        begin
            comparator_event_flag_r <= (comparator_event_flag_r & ~w_data_r[1:0]) | event_pulse;
        end
        else
        begin
            comparator_event_flag_r <= comparator_event_flag_r | event_pulse;
        end
    end

    // Events keep flowing in sleep, so an unmasked one both interrupts and wakes
    assign irq = |(comparator_event_flag_r & int_mask_r);
    assign wake_req = sleep_active & irq;

    // Read path: one read at a time, answered the cycle after it is taken
    assign arready = ~rvalid_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;

    always_comb
    begin
        rd_hit = 1'b1;
        case (araddr)
            A_REF: rd_byte = voltage_reference_control_r;
            A_CMP1: rd_byte = comparator_one_control_r;
            A_CMP2: rd_byte = comparator_two_control_r;
            A_STAT: rd_byte = {6'h00, result};
            A_IST: rd_byte = {6'h00, comparator_event_flag_r};
            A_IMSK: rd_byte = {6'h00, int_mask_r};
            default:
            begin
                rd_byte = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `CMPREF_RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= {24'h00_0000, rd_byte};
            rresp_r <= rd_hit ? `CMPREF_RESP_OKAY : `CMPREF_RESP_SLVERR;
        end
        else if (rready)
        begin
            rvalid_r <= 1'b0;
        end
    end

    // Reference ladder has no dependence on comparator state
    cmpref_ref_drive u_ref (
        .ctrl(voltage_reference_control_r),
        .pin_direction(pin_direction),
        .ref_power_on(ref_power_on),
        .ref_range_select(ref_range_select),
        .ref_source_select(ref_source_select),
        .ref_tap_code(ref_tap_code),
        .ref_pin_drive(ref_pin_drive),
        .shared_pin_digital_oe(shared_pin_digital_oe)
    );

    cmpref_cmp_chan u_cmp1 (
        .aclk(aclk),
        .aresetn(aresetn),
        .ctrl(comparator_one_control_r),
        .raw_in(comparator_raw[0]),
        .on(chan_on[0]),
        .pin_drive(chan_pin[0]),
        .pos_sel(chan_pos[0]),
        .neg_sel(neg0),
        .result_r(result[0]),
        .event_pulse(event_pulse[0])
    );

    cmpref_cmp_chan u_cmp2 (
        .aclk(aclk),
        .aresetn(aresetn),
        .ctrl(comparator_two_control_r),
        .raw_in(comparator_raw[1]),
        .on(chan_on[1]),
        .pin_drive(chan_pin[1]),
        .pos_sel(chan_pos[1]),
        .neg_sel(neg1),
        .result_r(result[1]),
        .event_pulse(event_pulse[1])
    );

    assign comparator_on = chan_on;
    assign comparator_pin_drive = chan_pin;
    assign positive_input_select = chan_pos;
    assign negative_channel_select = {neg1, neg0};
    assign comparator_one_result = result[0];
    assign comparator_two_result = result[1];

    // Protection bits carry no meaning here
    logic unused_prot;
    assign unused_prot = ^{awprot, arprot, wdata[31:8], wstrb[3:1]};
endmodule : cmpref_top

/* include/cmpref_cfg.svh */
// Register map, field positions, reset values and bus codes for the reference control block
`ifndef CMPREF_CFG_SVH
`define CMPREF_CFG_SVH

`define CMPREF_ADDR_W 16
`define CMPREF_IDX_REF_CTRL 16'h0f53
`define CMPREF_IDX_CMP1_CTRL 16'h0f54
`define CMPREF_IDX_CMP2_CTRL 16'h0f55
`define CMPREF_IDX_CMP_STAT 16'h0f56
`define CMPREF_IDX_INT_STAT 16'h0f57
`define CMPREF_IDX_INT_MASK 16'h0f58
`define CMPREF_BYTE_ADDR(idx) ((idx) << 2)

`define CMPREF_REF_POWER_BIT 7
`define CMPREF_REF_PIN_BIT 6
`define CMPREF_REF_RANGE_BIT 5
`define CMPREF_REF_SOURCE_BIT 4
`define CMPREF_REF_TAP_HI 3
`define CMPREF_REF_TAP_LO 0

`define CMPREF_CMP_ON_BIT 7
`define CMPREF_CMP_PIN_BIT 6
`define CMPREF_CMP_INV_BIT 5
`define CMPREF_CMP_EV_HI 4
`define CMPREF_CMP_EV_LO 3
`define CMPREF_CMP_POS_BIT 2
`define CMPREF_CMP_NEG_HI 1
`define CMPREF_CMP_NEG_LO 0

`define CMPREF_REF_RESET 8'h00
`define CMPREF_CMP_RESET 8'h00
`define CMPREF_MASK_RESET 2'h0

`define CMPREF_RESP_OKAY 2'h0
`define CMPREF_RESP_SLVERR 2'h2

`endif

/* include/cmpref_pkg.sv */
// Types shared by the reference control block
package cmpref_pkg;
    typedef logic [7:0] cmpref_byte_t;
    typedef enum logic [1:0] {EV_NONE, EV_RISE, EV_FALL, EV_ANY} cmpref_evsel_t;
    typedef enum logic {WR_IDLE, WR_RESP} cmpref_wr_state_t;
endpackage : cmpref_pkg

/* rtl/cmpref_cmp_chan.sv */
// One comparator channel: enable, polarity, result register and event detection
`timescale 1ns/10ps
`include "cmpref_cfg.svh"
module cmpref_cmp_chan
    import cmpref_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control and analog result
    input wire cmpref_byte_t ctrl,
    input wire logic raw_in,
    // Derived outputs
    output logic on,
    output logic pin_drive,
    output logic pos_sel,
    output logic [1:0] neg_sel,
    output logic result_r,
    output logic event_pulse
);
    logic level;
    logic prev_r;
    cmpref_evsel_t evsel;

    assign on = ctrl[`CMPREF_CMP_ON_BIT];
    assign pin_drive = ctrl[`CMPREF_CMP_PIN_BIT];
    assign pos_sel = ctrl[`CMPREF_CMP_POS_BIT];
    assign neg_sel = ctrl[`CMPREF_CMP_NEG_HI:`CMPREF_CMP_NEG_LO];
    assign evsel = cmpref_evsel_t'(ctrl[`CMPREF_CMP_EV_HI:`CMPREF_CMP_EV_LO]);
    // Switched-off comparator reads low, inverted before everything else
    assign level = on & (raw_in ^ ctrl[`CMPREF_CMP_INV_BIT]);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            result_r <= 1'b0;
            prev_r <= 1'b0;
        end
        else
        begin
            result_r <= level;
            prev_r <= result_r;
        end
    end

    always_comb
    begin
        case (evsel)
            EV_RISE: event_pulse = result_r & ~prev_r;
            EV_FALL: event_pulse = ~result_r & prev_r;
            EV_ANY: event_pulse = result_r ^ prev_r;
            default: event_pulse = 1'b0;
        endcase
    end
endmodule : cmpref_cmp_chan

/* rtl/cmpref_ref_drive.sv */
// Ladder control levels and shared analog pin routing
`timescale 1ns/10ps
`include "cmpref_cfg.svh"
module cmpref_ref_drive
    import cmpref_pkg::*;
(
    // Reference control register and pin direction
    input wire cmpref_byte_t ctrl,
    input wire logic pin_direction,
    // Ladder controls
    output logic ref_power_on,
    output logic ref_range_select,
    output logic ref_source_select,
    output logic [3:0] ref_tap_code,
    // Shared pin
    output logic ref_pin_drive,
    output logic shared_pin_digital_oe
);
    assign ref_power_on = ctrl[`CMPREF_REF_POWER_BIT];
    assign ref_range_select = ctrl[`CMPREF_REF_RANGE_BIT];
    assign ref_source_select = ctrl[`CMPREF_REF_SOURCE_BIT];
    assign ref_tap_code = ctrl[`CMPREF_REF_TAP_HI:`CMPREF_REF_TAP_LO];
    assign ref_pin_drive = ctrl[`CMPREF_REF_PIN_BIT];
    // Ladder routing wins over the digital driver regardless of direction
    assign shared_pin_digital_oe = ~ref_pin_drive & ~pin_direction;
endmodule : cmpref_ref_drive

/* tb/cmpref_ctl_monitor.sv */
// Port checks for the comparator reference control block
`timescale 1ns/10ps
module cmpref_ctl_monitor
(
    // Clock, reset and bus
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    // Power, pin, ladder and comparators
    input wire logic sleep_active,
    input wire logic wake_req,
    input wire logic irq,
    input wire logic pin_direction,
    input wire logic ref_power_on,
    input wire logic ref_pin_drive,
    input wire logic ref_range_select,
    input wire logic ref_source_select,
    input wire logic [3:0] ref_tap_code,
    input wire logic shared_pin_digital_oe,
    input wire logic [1:0] comparator_on,
    input wire logic comparator_one_result
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic [7:0] ladder;
    assign ladder = {ref_power_on, ref_pin_drive, ref_range_select, ref_source_select,
        ref_tap_code};
    a_pin_oe: assert property (shared_pin_digital_oe == (!ref_pin_drive && !pin_direction))
        else $error("shared pin enable wrong");
    a_wake_level: assert property (wake_req == (sleep_active && irq))
        else $error("wake request wrong");
    // Only a committed write may move controls, sleep or not
    a_ctrl_hold: assert property (!$rose(bvalid) |->
        $stable(ladder) && $stable(comparator_on))
        else $error("controls moved without write");
    a_reset_clear: assert property (disable iff (1'b0)
        !aresetn |=> ladder == 8'h00 && comparator_on == 2'h0)
        else $error("reset left controls set");
    a_result_off: assert property (!comparator_on[0] |=> !comparator_one_result)
        else $error("result while off");
    a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    a_read_ans: assert property (arvalid && arready |=> rvalid)
        else $error("read not answered");
    a_rdata_top: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    a_irq_fall: assert property ($fell(irq) |-> $rose(bvalid))
        else $error("irq cleared without write");
    a_busy_refuse: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while busy");
    cover property ($rose(irq));
    cover property (sleep_active && wake_req);
    cover property (bvalid && bresp == 2'h2);
    cover property (rvalid && rready);
endmodule : cmpref_ctl_monitor

bind cmpref_top cmpref_ctl_monitor u_mon (.aclk, .aresetn, .awready, .wready, .bvalid,
    .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .sleep_active,
    .wake_req, .irq, .pin_direction, .ref_power_on, .ref_pin_drive, .ref_range_select,
    .ref_source_select, .ref_tap_code, .shared_pin_digital_oe, .comparator_on,
    .comparator_one_result);

/* tb/cmpref_analog_model.sv */
// Behavioural ladder and two comparators
`timescale 1ns/10ps
module cmpref_analog_model #(
    parameter int THR = 40
)
(
    // Ladder and comparator controls
    input wire logic ref_power_on,
    input wire logic ref_range_select,
    input wire logic [3:0] ref_tap_code,
    input wire logic [1:0] comparator_on,
    input wire logic [1:0] positive_input_select,
    // External positive pins, full scale or zero
    input wire logic [1:0] pin_level,
    // Raw results
    output logic [1:0] comparator_raw
);
    int lvl;
    // Levels in 96ths of source so both step sizes stay integral
    always_comb
    begin
        if (!ref_power_on)
            lvl = 0;
        else if (ref_range_select)
            lvl = 4 * int'(ref_tap_code);
        else
            lvl = 24 + 3 * int'(ref_tap_code);
        for (int i = 0; i < 2; i++)
            comparator_raw[i] = comparator_on[i]
                && ((positive_input_select[i] ? lvl : 96 * int'(pin_level[i])) > THR);
    end
endmodule : cmpref_analog_model

/* tb/test_comparator_reference_control.sv */
// Self-checking bench for the comparator reference control block
`timescale 1ns/10ps
`include "cmpref_cfg.svh"
module test_comparator_reference_control;
    import cmpref_pkg::*;
    logic aclk = 0;
    logic aresetn = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [15:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = 4'h1;
    logic sleep_active = 0, pin_direction = 0;
    logic [1:0] pin_level = '0, comparator_raw;
    logic awready, wready, bvalid, arready, rvalid, wake_req, irq;
    logic ref_power_on, ref_range_select, ref_source_select, ref_pin_drive, shared_pin_digital_oe;
    logic [3:0] ref_tap_code, negative_channel_select;
    logic [1:0] bresp, rresp, comparator_on, positive_input_select, comparator_pin_drive;
    logic comparator_one_result, comparator_two_result;
    logic [31:0] rdata;
    logic [33:0] rd_q[$];
    logic [1:0] b_q[$];
    logic [7:0] v, w;
    logic [23:0] lad[8] = '{24'h84_aa00, 24'h84_ab01, 24'h84_8500, 24'h84_8601, 24'h84_2f00,
        24'ha4_ab00, 24'ha4_2f01, 24'h04_ab00};
    int n_mismatch = 0, checks = 0, cyc = 0;

    cmpref_top uut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid,
        .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
        .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .sleep_active, .wake_req,
        .ref_power_on, .ref_range_select, .ref_source_select, .ref_tap_code, .pin_direction,
        .ref_pin_drive, .shared_pin_digital_oe, .comparator_raw, .comparator_on,
        .positive_input_select, .negative_channel_select, .comparator_pin_drive,
        .comparator_one_result, .comparator_two_result, .irq);
    cmpref_analog_model u_ana (.ref_power_on, .ref_range_select, .ref_tap_code,
        .comparator_on, .positive_input_select, .pin_level, .comparator_raw);

    always #12.5 aclk = ~aclk;

    task automatic end_of_test;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
        checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    function automatic logic [15:0] ba(input logic [15:0] i);
        return {i[13:0], 2'b00};
    endfunction : ba

    task automatic wr(input logic [15:0] i, input logic [7:0] d, input logic [1:0] er);
        awaddr <= ba(i);
        wdata <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b_q.push_back(er);
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (!bvalid);
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [15:0] i, input logic [7:0] d, input logic [1:0] er);
        araddr <= ba(i);
        arvalid <= 1'b1;
        rready <= 1'b1;
        rd_q.push_back({er, 24'h00_0000, d});
        do
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end
        while (!rvalid);
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    // Results are matched against notes in issue order
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (rvalid && rready)
            chk("rdata", rd_q.pop_front(), {rresp, rdata});
        if (bvalid && bready)
            chk("bresp", 34'(b_q.pop_front()), 34'(bresp));
        if (cyc == 20000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end

    initial
    begin
        void'($urandom(52263));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int k = 3; k < 9; k++)
            rd(16'h0f50 + 16'(k), 8'h00, `CMPREF_RESP_OKAY);
        rd(16'h0f59, 8'h00, `CMPREF_RESP_SLVERR);
        wr(16'h0f59, 8'hff, `CMPREF_RESP_SLVERR);
        repeat (6)
        begin
            v = 8'($urandom);
            w = 8'($urandom);
            pin_direction <= 1'($urandom);
            wr(`CMPREF_IDX_REF_CTRL, v, `CMPREF_RESP_OKAY);
            chk("ladder", 34'(v), 34'({ref_power_on, ref_pin_drive, ref_range_select,
                ref_source_select, ref_tap_code}));
            chk("pin_oe", 34'(!v[6] && !pin_direction), 34'(shared_pin_digital_oe));
            rd(`CMPREF_IDX_REF_CTRL, v, `CMPREF_RESP_OKAY);
            wr(`CMPREF_IDX_CMP1_CTRL, w, `CMPREF_RESP_OKAY);
            wr(`CMPREF_IDX_CMP2_CTRL, ~w, `CMPREF_RESP_OKAY);
            chk("cmp_on", 34'({~w[7], w[7]}), 34'(comparator_on));
            chk("cmp_pin", 34'({~w[6], w[6]}), 34'(comparator_pin_drive));
            chk("cmp_pos", 34'({~w[2], w[2]}), 34'(positive_input_select));
            chk("cmp_neg", 34'({~w[1:0], w[1:0]}), 34'(negative_channel_select));
        end
        wr(`CMPREF_IDX_CMP2_CTRL, 8'h00, `CMPREF_RESP_OKAY);
        // Strobe low must store nothing
        wstrb <= 4'h0;
        wr(`CMPREF_IDX_REF_CTRL, ~v, `CMPREF_RESP_OKAY);
        wstrb <= 4'h1;
        rd(`CMPREF_IDX_REF_CTRL, v, `CMPREF_RESP_OKAY);
        foreach (lad[k])
        begin
            wr(`CMPREF_IDX_CMP1_CTRL, lad[k][23:16], `CMPREF_RESP_OKAY);
            wr(`CMPREF_IDX_REF_CTRL, lad[k][15:8], `CMPREF_RESP_OKAY);
            rd(`CMPREF_IDX_CMP_STAT, lad[k][7:0], `CMPREF_RESP_OKAY);
        end
        wr(`CMPREF_IDX_INT_MASK, 8'h02, `CMPREF_RESP_OKAY);
        for (int m = 0; m < 4; m++)
        begin
            // Last mode runs asleep with ladder and comparator two still on
            sleep_active <= (m == 3);
            wr(`CMPREF_IDX_CMP2_CTRL, 8'h80 | 8'(m << 3), `CMPREF_RESP_OKAY);
            wr(`CMPREF_IDX_INT_STAT, 8'h03, `CMPREF_RESP_OKAY);
            pin_level[1] <= 1'b1;
            repeat (3) @(posedge aclk);
            chk("irq", 34'(m[0]), 34'(irq));
            chk("wake", 34'(m == 3), 34'(wake_req));
            chk("res2", 34'(1), 34'(comparator_two_result));
            rd(`CMPREF_IDX_INT_STAT, 8'(m[0]) << 1, `CMPREF_RESP_OKAY);
            wr(`CMPREF_IDX_INT_STAT, 8'h03, `CMPREF_RESP_OKAY);
            pin_level[1] <= 1'b0;
            repeat (3) @(posedge aclk);
            rd(`CMPREF_IDX_INT_STAT, 8'(m[1]) << 1, `CMPREF_RESP_OKAY);
        end
        wr(`CMPREF_IDX_INT_MASK, 8'h00, `CMPREF_RESP_OKAY);
        chk("irq", 34'(0), 34'(irq));
        // Wake first, then confirm nothing moved
        sleep_active <= 1'b0;
        rd(`CMPREF_IDX_CMP2_CTRL, 8'h98, `CMPREF_RESP_OKAY);
        rd(`CMPREF_IDX_REF_CTRL, 8'hab, `CMPREF_RESP_OKAY);
        // Power down before sleeping again; other fields kept so reset still shows
        wr(`CMPREF_IDX_REF_CTRL, 8'h2b, `CMPREF_RESP_OKAY);
        wr(`CMPREF_IDX_CMP2_CTRL, 8'h18, `CMPREF_RESP_OKAY);
        sleep_active <= 1'b1;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`CMPREF_IDX_REF_CTRL, 8'h00, `CMPREF_RESP_OKAY);
        rd(`CMPREF_IDX_CMP2_CTRL, 8'h00, `CMPREF_RESP_OKAY);
        end_of_test();
    end
endmodule : test_comparator_reference_control
